// [verilog/amp_ctrl_pkg.sv]
// constants shared by the amplifier wake and status logic
`default_nettype none
package amp_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] irq_status_off = 8'h08;
  localparam logic [7:0] irq_mask_off = 8'h0C;
  localparam logic [7:0] amp_warn_off = 8'h10;
  localparam logic [7:0] supply_warn_off = 8'h14;
  localparam logic [7:0] temp_off = 8'h18;
  localparam logic [7:0] temp_floor_off = 8'h1C;
  // ctrl bit positions
  localparam int ctrl_standby_bit = 0;
  localparam int ctrl_checks_bit = 1;
  // irq bit positions
  localparam int irq_thermal_bit = 0;
  localparam int irq_oc1_bit = 1;
  localparam int irq_oc2_bit = 2;
  localparam int irq_wake_bit = 3;
  localparam int irq_fault_bit = 4;
  localparam int irq_width = 5;
  // reset values
  localparam logic [31:0] ctrl_reset = 32'h0000_0001;
  localparam logic [31:0] warn_reset = 32'h0000_00FF;
  localparam logic [31:0] floor_reset = 32'h0000_0000;
  // times in ns and clock cycles at 200 MHz
  localparam int clk_period_ns = 5;
  localparam int oc_pulse_ns = 50000;
  localparam int oc_pulse_cycles = (oc_pulse_ns + clk_period_ns - 1)
                                   / clk_period_ns;
  localparam int standby_release_cycles = 64;
  localparam int on_release_cycles = 64;
  localparam int audio_hold_cycles = 1000000;
  // response codes
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage : amp_ctrl_pkg
`default_nettype wire

// [verilog/oc_stretch.sv]
// overcurrent pulse stretcher for one channel
`timescale 1ns/1ps
`default_nettype none
module oc_stretch #(
  parameter int min_cycles = 10000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // limiter event and stretched active-low flag
  input wire logic event_in,
  output logic flag_n
);
  localparam int cw = $clog2(min_cycles + 1);
  logic [cw-1:0] count;

  // restarts on every event so the flag stays low at least min_cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (event_in) begin
      count <= cw'(min_cycles);
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_n <= 1'b1;
    end else begin
      flag_n <= !(event_in || count > cw'(1));
    end
  end
endmodule : oc_stretch
`default_nettype wire

// [verilog/amp_wake_and_status_flags.sv]
// wake control, status flags and temperature report with axi4-lite regs
// Notes on behaviour
// - thermal alert low when either threshold reached
// - thermal alert releases itself when cooled
// - per-channel active-low overcurrent flag on events
// - overcurrent flags stretched to minimum width
// - single-channel build never drives channel two
// - trigger high wakes device from standby
// - audio detection wakes when trigger low
// - audio hold timer restarts on each detection
// - running hold timer overrides standby request
// - reported temperature is maximum of sensors
// - readings below floor clamp to floor
// - temperature keeps updating during thermal shutdown
// - standby flag low in standby, delayed release
// - on flag goes low immediately on wake
// - on flag release delayed on power down
// - amp ok low after checks, released on fault
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module amp_wake_and_status_flags #(
  parameter int two_channels = 1,
  parameter int n_sensors = 4,
  parameter int temp_width = 8,
  parameter int oc_cycles = amp_ctrl_pkg::oc_pulse_cycles,
  parameter int hold_cycles = amp_ctrl_pkg::audio_hold_cycles,
  parameter int standby_indicator_n_rel_cycles = amp_ctrl_pkg::standby_release_cycles,
  parameter int on_rel_cycles = amp_ctrl_pkg::on_release_cycles
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // wake inputs
  input wire logic standby_in,
  input wire logic trigger_in,
  input wire logic audio_presence_input,
  // sensor readings and fault inputs
  input wire logic [n_sensors*temp_width-1:0] amp_temps,
  input wire logic [temp_width-1:0] supply_temp,
  input wire logic ch1_limit_event,
  input wire logic ch2_limit_event,
  input wire logic amp_fault,
  // status outputs
  output logic thermal_alert_n,
  output logic ch1_overcurrent_n,
  output logic ch2_overcurrent_n,
  output logic ch2_overcurrent_oe,
  output logic standby_indicator_n,
  output logic on_indicator_n,
  output logic amp_ok_n,
  output logic [temp_width-1:0] temp_report,
  output logic irq
);
  typedef enum logic [1:0] {
    st_standby = 2'b00,
    st_starting = 2'b01,
    st_on = 2'b10,
    st_stopping = 2'b11
  } mode_e;

  localparam int hw = $clog2(hold_cycles + 1);
  localparam int dw = $clog2(standby_indicator_n_rel_cycles + on_rel_cycles + 2);

  mode_e mode;
  logic [31:0] ctrl;
  logic [temp_width-1:0] amp_warn_threshold;
  logic [temp_width-1:0] supply_warn_threshold;
  logic [temp_width-1:0] temp_floor;
  logic [amp_ctrl_pkg::irq_width-1:0] irq_status;
  logic [amp_ctrl_pkg::irq_width-1:0] irq_mask;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic standby_s;
  logic trigger_s;
  logic audio_s;
  logic [hw-1:0] hold;
  logic [dw-1:0] delay;
  logic wake;
  logic amp_max_hot;
  logic [temp_width-1:0] amp_max;
  logic [temp_width-1:0] next_temp;
  logic ch1_flag_n;
  logic ch2_flag_n;
  logic ch1_prev;
  logic ch2_prev;
  logic thermal_prev;
  logic fault_prev;
  logic [7:0] aw_addr_q;
  logic aw_held;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_held;
  logic do_write;
  logic [amp_ctrl_pkg::irq_width-1:0] irq_events;
  logic [amp_ctrl_pkg::irq_width-1:0] irq_clear;

  // two-stage synchronisers; only stage two is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {audio_presence_input, trigger_in, standby_in};
      sync_b <= sync_a;
    end
  end
  assign standby_s = sync_b[0] | ctrl[amp_ctrl_pkg::ctrl_standby_bit];
  assign trigger_s = sync_b[1];
  assign audio_s = sync_b[2];

  // hold timer restarted by each detection, trigger takes precedence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold <= '0;
    end else if (audio_s && !trigger_s) begin
      hold <= hw'(hold_cycles);
    end else if (hold != '0) begin
      hold <= hold - 1'b1;
    end
  end

  // awake when standby not requested, trigger high, or audio held
  assign wake = !standby_s || trigger_s
                || (audio_s && !trigger_s) || hold != '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= st_standby;
      delay <= '0;
    end else begin
      case (mode)
        st_standby: if (wake) begin
          mode <= st_starting;
          delay <= dw'(standby_indicator_n_rel_cycles);
        end
        st_starting: if (!wake) begin
          mode <= st_stopping;
          delay <= dw'(on_rel_cycles);
        end else if (delay <= dw'(1)) begin
          mode <= st_on;
        end else begin
          delay <= delay - 1'b1;
        end
        st_on: if (!wake) begin
          mode <= st_stopping;
          delay <= dw'(on_rel_cycles);
        end
        st_stopping: if (wake) begin
          mode <= st_starting;
          delay <= dw'(standby_indicator_n_rel_cycles);
        end else if (delay <= dw'(1)) begin
          mode <= st_standby;
        end else begin
          delay <= delay - 1'b1;
        end
        default: mode <= st_standby;
      endcase
    end
  end

  // standby flag stays low until the release delay expires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_indicator_n <= 1'b0;
      on_indicator_n <= 1'b1;
      amp_ok_n <= 1'b1;
    end else begin
      standby_indicator_n <= (mode == st_on);
      on_indicator_n <= !(mode != st_standby);
      amp_ok_n <= !(mode == st_on
                    && ctrl[amp_ctrl_pkg::ctrl_checks_bit] && !amp_fault);
    end
  end

  // hottest amplifier sensor
  always_comb begin
    amp_max = amp_temps[temp_width-1:0];
    amp_max_hot = 1'b0;
    for (int i = 1; i < n_sensors; i++) begin
      if (amp_temps[i*temp_width +: temp_width] > amp_max) begin
        amp_max = amp_temps[i*temp_width +: temp_width];
      end
    end
    next_temp = (supply_temp > amp_max) ? supply_temp : amp_max;
    if (next_temp < temp_floor) begin
      next_temp = temp_floor;
    end
    amp_max_hot = amp_max >= amp_warn_threshold;
  end

  // no gating by fault or mode: reading keeps updating in shutdown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_report <= '0;
      thermal_alert_n <= 1'b1;
    end else begin
      temp_report <= next_temp;
      thermal_alert_n <= !(amp_max_hot
                           || supply_temp >= supply_warn_threshold);
    end
  end

  oc_stretch #(.min_cycles(oc_cycles)) u_oc1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_in(ch1_limit_event),
    .flag_n(ch1_flag_n)
  );

  oc_stretch #(.min_cycles(oc_cycles)) u_oc2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_in(ch2_limit_event && two_channels != 0),
    .flag_n(ch2_flag_n)
  );

  assign ch1_overcurrent_n = ch1_flag_n;
  // single-channel build: pin undriven, enable held low
  assign ch2_overcurrent_n = (two_channels != 0) ? ch2_flag_n : 1'b1;
  assign ch2_overcurrent_oe = (two_channels != 0);

  // edge detect for sticky interrupt sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch1_prev <= 1'b1;
      ch2_prev <= 1'b1;
      thermal_prev <= 1'b1;
      fault_prev <= 1'b0;
    end else begin
      ch1_prev <= ch1_flag_n;
      ch2_prev <= ch2_overcurrent_n;
      thermal_prev <= thermal_alert_n;
      fault_prev <= amp_fault;
    end
  end

  always_comb begin
    irq_events = '0;
    irq_events[amp_ctrl_pkg::irq_thermal_bit] = thermal_prev
                                                && !thermal_alert_n;
    irq_events[amp_ctrl_pkg::irq_oc1_bit] = ch1_prev && !ch1_flag_n;
    irq_events[amp_ctrl_pkg::irq_oc2_bit] = ch2_prev && !ch2_overcurrent_n;
    irq_events[amp_ctrl_pkg::irq_wake_bit] = (mode == st_standby) && wake;
    irq_events[amp_ctrl_pkg::irq_fault_bit] = !fault_prev && amp_fault;
  end

  // axi4-lite write: address and data taken independently
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= amp_ctrl_pkg::resp_okay;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr_q > amp_ctrl_pkg::temp_floor_off
                  || aw_addr_q[1:0] != 2'b00)
                 ? amp_ctrl_pkg::resp_slverr : amp_ctrl_pkg::resp_okay;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign irq_clear = (do_write && aw_addr_q == amp_ctrl_pkg::irq_status_off
                      && w_strb_q[0])
                     ? w_data_q[amp_ctrl_pkg::irq_width-1:0] : '0;

  // set wins over clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= amp_ctrl_pkg::ctrl_reset;
      irq_mask <= '0;
      amp_warn_threshold <= temp_width'(amp_ctrl_pkg::warn_reset);
      supply_warn_threshold <= temp_width'(amp_ctrl_pkg::warn_reset);
      temp_floor <= temp_width'(amp_ctrl_pkg::floor_reset);
    end else if (do_write && w_strb_q[0]) begin
      case (aw_addr_q)
        amp_ctrl_pkg::ctrl_off: ctrl <= {30'h0, w_data_q[1:0]};
        amp_ctrl_pkg::irq_mask_off:
          irq_mask <= w_data_q[amp_ctrl_pkg::irq_width-1:0];
        amp_ctrl_pkg::amp_warn_off:
          amp_warn_threshold <= w_data_q[temp_width-1:0];
        amp_ctrl_pkg::supply_warn_off:
          supply_warn_threshold <= w_data_q[temp_width-1:0];
        amp_ctrl_pkg::temp_floor_off:
          temp_floor <= w_data_q[temp_width-1:0];
        default: ;
      endcase
    end
  end

  assign irq = |(irq_status & irq_mask);

  // axi4-lite read: one cycle to rvalid
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= amp_ctrl_pkg::resp_okay;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= amp_ctrl_pkg::resp_okay;
      case (araddr)
        amp_ctrl_pkg::ctrl_off: rdata <= ctrl;
        amp_ctrl_pkg::status_off: rdata <= {22'h0, amp_ok_n, on_indicator_n,
          standby_indicator_n, ch2_overcurrent_n, ch1_overcurrent_n,
          thermal_alert_n, hold != '0, wake, 2'(mode)};
        amp_ctrl_pkg::irq_status_off: rdata <= 32'(irq_status);
        amp_ctrl_pkg::irq_mask_off: rdata <= 32'(irq_mask);
        amp_ctrl_pkg::amp_warn_off: rdata <= 32'(amp_warn_threshold);
        amp_ctrl_pkg::supply_warn_off: rdata <= 32'(supply_warn_threshold);
        amp_ctrl_pkg::temp_off: rdata <= 32'(temp_report);
        amp_ctrl_pkg::temp_floor_off: rdata <= 32'(temp_floor);
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= amp_ctrl_pkg::resp_slverr;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : amp_wake_and_status_flags
`default_nettype wire

// [tb/amp_flags_props.sv]
// assertion checker for the amplifier wake and status flags
`timescale 1ns/1ps
`default_nettype none
module amp_flags_props #(
  parameter int two_channels = 1,
  parameter int n_sensors = 4,
  parameter int temp_width = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // inputs watched
  input wire logic trigger_in,
  input wire logic [n_sensors*temp_width-1:0] amp_temps,
  input wire logic ch1_limit_event,
  input wire logic amp_fault,
  // outputs watched
  input wire logic ch1_overcurrent_n,
  input wire logic ch2_overcurrent_oe,
  input wire logic standby_indicator_n,
  input wire logic on_indicator_n,
  input wire logic amp_ok_n,
  input wire logic [temp_width-1:0] temp_report
);
  logic [temp_width-1:0] amax;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_comb begin
    amax = '0;
    for (int i = 0; i < n_sensors; i++) begin
      if (amp_temps[i*temp_width +: temp_width] > amax) begin
        amax = amp_temps[i*temp_width +: temp_width];
      end
    end
  end
  sequence s_started;
    $rose(standby_indicator_n);
  endsequence
  sequence s_stopping;
    $fell(standby_indicator_n);
  endsequence
  sequence s_trig;
    trigger_in [*3];
  endsequence
  AST_OC_SET: assert property (ch1_limit_event |=> !ch1_overcurrent_n)
    else $error("overcurrent flag not set after event");
  AST_OC_QUIET: assert property (
    ch1_overcurrent_n && !ch1_limit_event |=> ch1_overcurrent_n)
    else $error("overcurrent flag set without event");
  AST_OC_STRETCH: assert property (
    $fell(ch1_overcurrent_n) |-> !ch1_overcurrent_n [*8])
    else $error("overcurrent flag shorter than minimum");
  AST_CH2_OE: assert property (ch2_overcurrent_oe == (two_channels != 0))
    else $error("channel two pin drive wrong for build");
  AST_TEMP_MAX: assert property (
    $stable(amp_temps) [*3] |-> temp_report >= amax)
    else $error("reported temperature below hottest sensor");
  AST_TRIG_WAKE: assert property (s_trig |-> ##[0:8] !on_indicator_n)
    else $error("trigger did not wake the device");
  AST_STANDBY_INDICATOR_N_DELAY: assert property (
    s_started |-> !on_indicator_n && !$past(on_indicator_n, 3))
    else $error("standby flag released without delay");
  AST_ON_HOLD: assert property (s_stopping |-> !on_indicator_n [*3])
    else $error("on flag released too early");
  AST_FAULT_OK: assert property (amp_fault |-> ##[1:2] amp_ok_n)
    else $error("ready flag kept during amplifier fault");
  AST_OK_ON: assert property (!amp_ok_n |-> !on_indicator_n)
    else $error("ready flag low outside operation");
endmodule : amp_flags_props
bind amp_wake_and_status_flags amp_flags_props #(
  .two_channels(two_channels),
  .n_sensors(n_sensors),
  .temp_width(temp_width)
) props (
  .aclk, .aresetn, .trigger_in, .amp_temps, .ch1_limit_event, .amp_fault,
  .ch1_overcurrent_n, .ch2_overcurrent_oe, .standby_indicator_n,
  .on_indicator_n, .amp_ok_n, .temp_report
);
`default_nettype wire

// [tb/status_reader.sv]
// front-end side of the open-collector channel two flag
`timescale 1ns/1ps
`default_nettype none
module status_reader (
  // pin as driven by the module
  input wire logic ch2_overcurrent_n,
  input wire logic ch2_overcurrent_oe,
  // level seen by the front end
  output logic ch2_line
);
  // released pin floats to the pull-up, never keeps the last level
  assign ch2_line = ch2_overcurrent_oe ? ch2_overcurrent_n : 1'b1;
endmodule : status_reader
`default_nettype wire

// [tb/tb_amp_wake_and_status_flags.sv]
// testbench for the amplifier wake and status flags
`timescale 1ns/1ps
`default_nettype none
module tb_amp_wake_and_status_flags;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, supply_temp, temp_report;
  logic [31:0] wdata, rdata, amp_temps;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic standby_in, trigger_in, audio_presence_input;
  logic ch1_limit_event, ch2_limit_event, amp_fault;
  logic thermal_alert_n, ch1_overcurrent_n, ch2_overcurrent_n;
  logic ch2_overcurrent_oe, standby_indicator_n, on_indicator_n;
  logic amp_ok_n, irq, ch2_line, irq_a;
  logic ch2_n_single, ch2_oe_single, ch2_line_single;
  int err_count, checks;
  // short counts keep the run brief
  amp_wake_and_status_flags #(.oc_cycles(8), .hold_cycles(20),
    .standby_indicator_n_rel_cycles(4), .on_rel_cycles(4)) dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .standby_in, .trigger_in,
    .audio_presence_input, .amp_temps, .supply_temp, .ch1_limit_event,
    .ch2_limit_event, .amp_fault, .thermal_alert_n, .ch1_overcurrent_n,
    .ch2_overcurrent_n, .ch2_overcurrent_oe, .standby_indicator_n,
    .on_indicator_n, .amp_ok_n, .temp_report, .irq);
  status_reader reader (.ch2_overcurrent_n, .ch2_overcurrent_oe, .ch2_line);
  // single-channel build sees the same stimulus; only its channel two is read
  amp_wake_and_status_flags #(.two_channels(0), .oc_cycles(8),
    .hold_cycles(20), .standby_indicator_n_rel_cycles(4), .on_rel_cycles(4)) dut_single (
    .aclk, .aresetn, .awvalid, .awready(), .awaddr, .wvalid, .wready(),
    .wdata, .wstrb, .bvalid(), .bready, .bresp(), .arvalid, .arready(),
    .araddr, .rvalid(), .rready, .rdata(), .rresp(), .standby_in,
    .trigger_in, .audio_presence_input, .amp_temps, .supply_temp,
    .ch1_limit_event, .ch2_limit_event, .amp_fault, .thermal_alert_n(),
    .ch1_overcurrent_n(), .ch2_overcurrent_n(ch2_n_single),
    .ch2_overcurrent_oe(ch2_oe_single), .standby_indicator_n(),
    .on_indicator_n(), .amp_ok_n(), .temp_report(), .irq());
  status_reader reader_single (.ch2_overcurrent_n(ch2_n_single),
    .ch2_overcurrent_oe(ch2_oe_single), .ch2_line(ch2_line_single));
  task automatic give_verdict();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // outputs are read at the falling edge, away from updates
  task automatic look(input int n, ref logic s, input logic v);
    tick(n);
    @(negedge aclk);
    chk(s, v);
    @(posedge aclk);
  endtask : look
  task automatic wait_for(ref logic s, input logic v);
    logic cur;
    int n;
    n = 0;
    cur = ~v;
    while (cur !== v && n < 80) begin
      @(negedge aclk);
      cur = s;
      @(posedge aclk);
      n++;
    end
    chk(cur, v);
  endtask : wait_for
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_h, w_h, b_h;
    int n;
    n = 0;
    b_h = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_h && n < 50) begin
      @(negedge aclk);
      aw_h = awvalid & awready;
      w_h = wvalid & wready;
      b_h = bvalid;
      if (b_h) chk(bresp, amp_ctrl_pkg::resp_okay);
      @(posedge aclk);
      if (aw_h) awvalid <= 1'b0;
      if (w_h) wvalid <= 1'b0;
      n++;
    end
    // bready stays high between writes so no edge sees it dropped and raised
    chk(b_h, 1'b1);
  endtask : axi_wr
  task automatic rd_chk(input logic [7:0] a, input logic [1:0] er,
                        input logic [31:0] exp);
    logic ar_h, r_h;
    logic [31:0] d;
    int n;
    n = 0;
    r_h = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_h && n < 50) begin
      @(negedge aclk);
      ar_h = arvalid & arready;
      r_h = rvalid;
      d = rdata;
      @(posedge aclk);
      if (ar_h) arvalid <= 1'b0;
      n++;
    end
    chk({r_h, rresp}, {1'b1, er});
    chk(d, exp);
  endtask : rd_chk
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial begin
    {err_count, checks} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {trigger_in, audio_presence_input, amp_fault} = '0;
    {ch1_limit_event, ch2_limit_event} = '0;
    standby_in = 1'b1;
    wstrb = 4'hF;
    amp_temps = 32'h141E_320A;
    supply_temp = 8'h05;
    tick(4);
    aresetn <= 1'b1;
    look(0, standby_indicator_n, 1'b0);
    look(0, ch2_line, 1'b1);
    rd_chk(amp_ctrl_pkg::ctrl_off, 2'b00, amp_ctrl_pkg::ctrl_reset);
    rd_chk(amp_ctrl_pkg::supply_warn_off, 2'b00, amp_ctrl_pkg::warn_reset);
    rd_chk(8'h20, amp_ctrl_pkg::resp_slverr, 32'h0);
    rd_chk(amp_ctrl_pkg::temp_off, 2'b00, 32'h32);
    axi_wr(amp_ctrl_pkg::temp_floor_off, 32'h60);
    rd_chk(amp_ctrl_pkg::temp_off, 2'b00, 32'h60);
    axi_wr(amp_ctrl_pkg::temp_floor_off, 32'h0);
    // thresholds reached exactly, then missed by one
    axi_wr(amp_ctrl_pkg::amp_warn_off, 32'h32);
    look(3, thermal_alert_n, 1'b0);
    axi_wr(amp_ctrl_pkg::amp_warn_off, 32'h33);
    look(3, thermal_alert_n, 1'b1);
    axi_wr(amp_ctrl_pkg::supply_warn_off, 32'h05);
    look(3, thermal_alert_n, 1'b0);
    axi_wr(amp_ctrl_pkg::supply_warn_off, 32'h06);
    look(3, thermal_alert_n, 1'b1);
    rd_chk(amp_ctrl_pkg::irq_status_off, 2'b00, 32'h1);
    axi_wr(amp_ctrl_pkg::irq_mask_off, 32'h0);
    @(negedge aclk);
    irq_a = irq;
    @(posedge aclk);
    axi_wr(amp_ctrl_pkg::irq_mask_off, 32'h1F);
    @(negedge aclk);
    chk({irq_a, irq}, 2'b01);
    @(posedge aclk);
    axi_wr(amp_ctrl_pkg::irq_status_off, 32'h1F);
    rd_chk(amp_ctrl_pkg::irq_status_off, 2'b00, 32'h0);
    look(0, irq, 1'b0);
    ch1_limit_event <= 1'b1;
    tick(1);
    ch1_limit_event <= 1'b0;
    look(1, ch1_overcurrent_n, 1'b0);
    look(4, ch1_overcurrent_n, 1'b0);
    look(8, ch1_overcurrent_n, 1'b1);
    ch2_limit_event <= 1'b1;
    tick(1);
    ch2_limit_event <= 1'b0;
    look(1, ch2_line, 1'b0);
    look(0, ch2_line_single, 1'b1);
    look(0, ch2_oe_single, 1'b0);
    rd_chk(amp_ctrl_pkg::irq_status_off, 2'b00, 32'h6);
    trigger_in <= 1'b1;
    wait_for(on_indicator_n, 1'b0);
    look(0, standby_indicator_n, 1'b0);
    wait_for(standby_indicator_n, 1'b1);
    axi_wr(amp_ctrl_pkg::ctrl_off, 32'h3);
    wait_for(amp_ok_n, 1'b0);
    rd_chk(amp_ctrl_pkg::status_off, 2'b00, 32'h0000_00F6);
    amp_fault <= 1'b1;
    look(2, amp_ok_n, 1'b1);
    amp_fault <= 1'b0;
    trigger_in <= 1'b0;
    wait_for(standby_indicator_n, 1'b0);
    look(1, on_indicator_n, 1'b0);
    wait_for(on_indicator_n, 1'b1);
    audio_presence_input <= 1'b1;
    tick(1);
    audio_presence_input <= 1'b0;
    wait_for(on_indicator_n, 1'b0);
    tick(10);
    // a second detection must restart the hold from its full count
    audio_presence_input <= 1'b1;
    tick(1);
    audio_presence_input <= 1'b0;
    look(18, on_indicator_n, 1'b0);
    wait_for(on_indicator_n, 1'b1);
    give_verdict();
  end
endmodule : tb_amp_wake_and_status_flags
`default_nettype wire
